/* dv/dmarq_src_model.sv */
// dmarq_src_model: external request sources beside the channel
// assumes the bench asks for a low request level through plain controls
`timescale 1ns/1ps
module dmarq_src_model (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic pin_low, // ask for a pin request
  input wire logic intr_low, // ask for an interrupt request
  output logic pin_transfer_request_n, // pin request, low active
  output logic intr_transfer_request_n // interrupt request, low active
);
  // sources idle high and pull low when active, like real request lines
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_transfer_request_n <= 1'h1;
      intr_transfer_request_n <= 1'h1;
    end else begin
      pin_transfer_request_n <= !pin_low;
      intr_transfer_request_n <= !intr_low;
    end
  end
endmodule // dmarq_src_model

/* dv/tb_dma_channel_request_config.sv */
// tb_dma_channel_request_config: self-checking bench for dmarq_top
// assumes the source model on the request pins and a plain register port
`timescale 1ns/1ps
module tb_dma_channel_request_config;
  import dmarq_pkg::*;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, rd_q = 0;
  logic [3:0] act = 4'h0;
  logic [7:0] reg_addr = 8'h00, lfsr_v = 8'h3f;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic xfer_request, pin_transfer_ack_n, snoop_bus_request, grant_bus_request, pin_n, intr_n;
  logic [31:0] exp_q[$];
  int fail_count = 0, total_checks = 0, cnt;
  always #2 clk = ~clk;
  dmarq_top DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr | act[2]), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .intr_transfer_request_n(intr_n),
    .pin_transfer_request_n(pin_n), .xfer_done(act[3]), .xfer_request(xfer_request),
    .pin_transfer_ack_n(pin_transfer_ack_n), .snoop_bus_request(snoop_bus_request),
    .grant_bus_request(grant_bus_request));
  dmarq_src_model SRC (.clk(clk), .arst_n(arst_n), .pin_low(act[0]), .intr_low(act[1]),
    .pin_transfer_request_n(pin_n), .intr_transfer_request_n(intr_n));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  // the expected read value is queued; the watcher below compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk) if (rd_q) chk("reg_rdata", reg_rdata, exp_q.pop_front());
  // hold one stimulus for len cycles, counting request or ack cycles over a window
  task automatic stim(input int kind, input int len, input int exp);
    @(posedge clk);
    reg_addr <= DMARQ_SWREQ_OFS;
    reg_wdata <= 32'h1;
    cnt = 0;
    fork
      begin
        act <= 4'h1 << kind;
        repeat (len) @(posedge clk);
        act <= 4'h0;
      end
      repeat (len + 12) begin
        @(negedge clk);
        cnt += (kind == 3) ? !pin_transfer_ack_n : xfer_request;
      end
    join
    chk("event count", cnt, exp);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    chk("snoop", snoop_bus_request, 1'h0);
    chk("grant", grant_bus_request, 1'h1);
    arst_n <= 1'h1;
    rd(DMARQ_CTRL_OFS, 32'h0);
    rd(DMARQ_STAT_OFS, 32'hc);
    rd(8'h0c, 32'h0);
    stim(0, 6, 0);
    stim(2, 1, 1);
    stim(3, 1, 0);
    wr(DMARQ_CTRL_OFS, 32'h4000);
    rd(DMARQ_CTRL_OFS, 32'h4000);
    stim(0, 6, 1);
    stim(3, 1, 1);
    wr(DMARQ_CTRL_OFS, 32'h5000);
    stim(0, 6, 6);
    stim(1, 6, 6);
    repeat (8) begin
      lfsr_v = lfsr(lfsr_v);
      wr(DMARQ_CTRL_OFS, {20'h0, lfsr_v[0], 11'h0});
      rd(DMARQ_CTRL_OFS, {20'h0, lfsr_v[0], 11'h0});
      @(negedge clk);
      chk("snoop", snoop_bus_request, lfsr_v[0]);
      chk("grant", grant_bus_request, !lfsr_v[0]);
    end
    print_verdict();
  end
  // watchdog well beyond the fewer than two hundred cycles the tests take
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
endmodule // tb_dma_channel_request_config

/* rtl/dmarq_pkg.sv */
// dmarq_pkg: constants and types for the dma channel request configuration block
// assumes a single 250 MHz clock and a plain register port
package dmarq_pkg;
  // register offset of the channel control word (low bits kept here)
  localparam logic [7:0] DMARQ_CTRL_OFS = 8'h00;
  localparam logic [7:0] DMARQ_STAT_OFS = 8'h04;
  localparam logic [7:0] DMARQ_SWREQ_OFS = 8'h08;
  // field positions inside the control word
  localparam int DMARQ_SRC_BIT = 14;
  localparam int DMARQ_POL_BIT = 13;
  localparam int DMARQ_LEV_BIT = 12;
  localparam int DMARQ_SHARE_BIT = 11;
  // reset values of the fields
  localparam logic DMARQ_SRC_RST = 1'h0;
  localparam logic DMARQ_POL_RST = 1'h0;
  localparam logic DMARQ_LEV_RST = 1'h0;
  localparam logic DMARQ_SHARE_RST = 1'h0;
  // only channels 0 and 4 carry external request inputs
  localparam int DMARQ_CHANNEL = 0;
  localparam logic DMARQ_EXT_CAPABLE = (DMARQ_CHANNEL == 0) || (DMARQ_CHANNEL == 4);
  localparam logic [1:0] DMARQ_SYNC_RST = 2'h3;

  typedef struct packed {
    logic src;   // 1: external request source
    logic pol;   // 1: prohibited polarity
    logic lev;   // 1: level sense, 0: edge sense
    logic share; // 1: snoop bus request, 0: grant bus request
  } dmarq_cfg_s;
endpackage : dmarq_pkg

/* rtl/dmarq_top.sv */
// dmarq_top: request source, sense style and bus share mode of one dma channel
// assumes synchronous register strobes and asynchronous external request pins
//
// How it works
// - source 0 takes software requests only
// - polarity bit is stored and read back only; requests stay low active for every setting
// - polarity 0: low or falling active, ack low
// - sense bit matters only for external source
// - level sense requests while input active
// - edge sense requests once per pin falling edge; the interrupt input still requests while low
// - share mode 1 issues snoop requests
// - share mode 0 issues grant requests
// - polarity, sense, share read zero after reset
// - source 1 takes interrupt or pin requests
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
module dmarq_top
  import dmarq_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, one cycle after strobe
  input wire logic intr_transfer_request_n, // interrupt-sourced request, low active
  input wire logic pin_transfer_request_n, // pin request, low active
  input wire logic xfer_done, // engine finished one transfer unit
  output logic xfer_request, // qualified transfer request pulse or level
  output logic pin_transfer_ack_n, // transfer acknowledge, low active
  output logic snoop_bus_request, // snoop-type bus request mode
  output logic grant_bus_request // grant-type bus request mode
);

  dmarq_cfg_s cfg, next_cfg;
  logic [31:0] next_rdata;
  logic [1:0] intr_sync, next_intr_sync;
  logic [1:0] pin_sync, next_pin_sync;
  logic pin_prev, next_pin_prev;
  logic sw_req, ext_req, next_req;
  logic next_ack_n, next_snoop, next_grant;

  // config register writes; source forced low where no external pins exist
  always_comb begin
    next_cfg = cfg;
    if (reg_wr && reg_addr == DMARQ_CTRL_OFS) begin
      next_cfg.src = reg_wdata[DMARQ_SRC_BIT] & DMARQ_EXT_CAPABLE;
      next_cfg.pol = reg_wdata[DMARQ_POL_BIT]; // stored only, see polarity note
      next_cfg.lev = reg_wdata[DMARQ_LEV_BIT];
      next_cfg.share = reg_wdata[DMARQ_SHARE_BIT];
    end
  end

  // register read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        DMARQ_CTRL_OFS: begin
          next_rdata[DMARQ_SRC_BIT] = cfg.src;
          next_rdata[DMARQ_POL_BIT] = cfg.pol;
          next_rdata[DMARQ_LEV_BIT] = cfg.lev;
          next_rdata[DMARQ_SHARE_BIT] = cfg.share;
        end
        DMARQ_STAT_OFS: next_rdata = {28'h0, pin_sync[1], intr_sync[1], ~pin_transfer_ack_n, xfer_request};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  // software start is a write of bit 0 at the software request offset
  assign sw_req = reg_wr && (reg_addr == DMARQ_SWREQ_OFS) && reg_wdata[0];

  // two-stage synchronisers; only the second stage is looked at
  always_comb begin
    next_intr_sync = {intr_sync[0], intr_transfer_request_n};
    next_pin_sync = {pin_sync[0], pin_transfer_request_n};
    next_pin_prev = pin_sync[1];
  end

  // request qualification; polarity bit is prohibited at 1 so inputs are always low active,
  // which keeps the external path safe even if software writes the forbidden value
  always_comb begin
    ext_req = 1'b0;
    if (cfg.lev) begin
      ext_req = ~pin_sync[1] | ~intr_sync[1];
    end else begin
      ext_req = (pin_prev & ~pin_sync[1]) | (~intr_sync[1]);
    end
    if (cfg.src) begin
      next_req = ext_req;
    end else begin
      next_req = sw_req;
    end
    next_ack_n = ~(cfg.src & xfer_done);
    next_snoop = cfg.share;
    next_grant = ~cfg.share;
  end

  // state and outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= '{src: DMARQ_SRC_RST, pol: DMARQ_POL_RST, lev: DMARQ_LEV_RST, share: DMARQ_SHARE_RST};
      reg_rdata <= 32'h0;
      intr_sync <= DMARQ_SYNC_RST;
      pin_sync <= DMARQ_SYNC_RST;
      pin_prev <= 1'b1;
      xfer_request <= 1'b0;
      pin_transfer_ack_n <= 1'b1;
      snoop_bus_request <= 1'b0;
      grant_bus_request <= 1'b1;
    end else begin
      cfg <= next_cfg;
      reg_rdata <= next_rdata;
      intr_sync <= next_intr_sync;
      pin_sync <= next_pin_sync;
      pin_prev <= next_pin_prev;
      xfer_request <= next_req;
      pin_transfer_ack_n <= next_ack_n;
      snoop_bus_request <= next_snoop;
      grant_bus_request <= next_grant;
    end
  end

  // checks
  property p_internal_only;
    @(posedge clk) disable iff (!arst_n)
    (!cfg.src && !sw_req) |=> !xfer_request;
  endproperty
  a_internal_only: assert property (p_internal_only) else $error("request without software start");

  property p_sw_req;
    @(posedge clk) disable iff (!arst_n)
    (!cfg.src && sw_req) |=> xfer_request;
  endproperty
  a_sw_req: assert property (p_sw_req) else $error("software start lost");

  property p_level;
    @(posedge clk) disable iff (!arst_n)
    (cfg.src && cfg.lev && !pin_sync[1]) |=> xfer_request;
  endproperty
  a_level: assert property (p_level) else $error("level request missed");

  property p_edge_once;
    @(posedge clk) disable iff (!arst_n)
    (cfg.src && !cfg.lev && intr_sync[1] && !pin_prev && !pin_sync[1]) |=> !xfer_request;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge mode repeats on held low");

  property p_edge_fire;
    @(posedge clk) disable iff (!arst_n)
    (cfg.src && !cfg.lev && pin_prev && !pin_sync[1]) |=> xfer_request;
  endproperty
  a_edge_fire: assert property (p_edge_fire) else $error("falling edge missed");

  property p_snoop;
    @(posedge clk) disable iff (!arst_n)
    cfg.share |=> (snoop_bus_request && !grant_bus_request);
  endproperty
  a_snoop: assert property (p_snoop) else $error("snoop mode not driven");

  property p_grant;
    @(posedge clk) disable iff (!arst_n)
    !cfg.share |=> (!snoop_bus_request && grant_bus_request);
  endproperty
  a_grant: assert property (p_grant) else $error("grant mode not driven");

  property p_ack_low;
    @(posedge clk) disable iff (!arst_n)
    (cfg.src && xfer_done) |=> !pin_transfer_ack_n;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not low");

  property p_sync_delay;
    @(posedge clk) disable iff (!arst_n)
    $fell(pin_transfer_request_n) |-> ##2 !pin_sync[1];
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

  property p_sync_rise;
    @(posedge clk) disable iff (!arst_n)
    $rose(pin_transfer_request_n) |-> ##2 pin_sync[1];
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("sync release delay wrong");

  // further checks: idle outputs, interrupt request while low, and read-back of the share bit
  property p_ack_idle;
    @(posedge clk) disable iff (!arst_n)
    (!cfg.src || !xfer_done) |=> pin_transfer_ack_n;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack low without external transfer");

  property p_intr_level;
    @(posedge clk) disable iff (!arst_n)
    (cfg.src && !intr_sync[1]) |=> xfer_request;
  endproperty
  a_intr_level: assert property (p_intr_level) else $error("interrupt request missed");

  property p_level_off;
    @(posedge clk) disable iff (!arst_n)
    (cfg.src && cfg.lev && pin_sync[1] && intr_sync[1]) |=> !xfer_request;
  endproperty
  a_level_off: assert property (p_level_off) else $error("level request while inputs idle");

  property p_share_read;
    @(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == DMARQ_CTRL_OFS) |=> (reg_rdata[DMARQ_SHARE_BIT] == $past(cfg.share));
  endproperty
  a_share_read: assert property (p_share_read) else $error("share bit read back wrong");

  property p_rdata_idle;
    @(posedge clk) disable iff (!arst_n)
    !reg_rd |=> (reg_rdata == 32'h0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read strobe");

  c_sw: cover property (@(posedge clk) disable iff (!arst_n) !cfg.src && sw_req ##1 xfer_request);
  c_edge: cover property (@(posedge clk) disable iff (!arst_n) cfg.src && !cfg.lev ##1 xfer_request);
  c_level: cover property (@(posedge clk) disable iff (!arst_n) cfg.src && cfg.lev && xfer_request [*3]);
  c_snoop: cover property (@(posedge clk) disable iff (!arst_n) snoop_bus_request);

endmodule // dmarq_top
